// ---- bit_ops_defs.svh ----
// constants of the bit test, compare and decrement execution slice
`ifndef BIT_OPS_DEFS_SVH
`define BIT_OPS_DEFS_SVH
// status flag positions in the five-bit flag word
`define FLAG_C         0
`define FLAG_DC        1
`define FLAG_N         2
`define FLAG_OV        3
`define FLAG_Z         4
// accumulator flag positions
`define ACC_OA         0
`define ACC_OB         1
`define ACC_SA         2
`define ACC_SB         3
// reset and fixed values
`define ZERO_WORD      16'h0000
`define ONE_WORD       16'h0001
`define FLAGS_RESET    5'h00
`define ACC_RESET      4'h0
`define CALL_RESET     23'h000000
// cycle and word counts
`define CYC_ONE        2'h1
`define CYC_TWO        2'h2
`define CYC_THREE      2'h3
`define WORDS_ONE      2'h1
`define WORDS_TWO      2'h2
// decimal adjust constants
`define BCD_NIBBLE_MAX 4'h9
`define BCD_ADJ_LO     9'h006
`define BCD_ADJ_HI     9'h060
`endif

// ---- bit_ops_pkg.sv ----
// types of the bit test, compare and decrement execution slice
`default_nettype none
package bit_ops_pkg;
  typedef enum logic [4:0] {
    BIT_PROBE            = 5'h00,
    BIT_PROBE_THEN_FORCE = 5'h01,
    SKIP_IF_BIT_LOW      = 5'h02,
    SKIP_IF_BIT_HIGH     = 5'h03,
    SUB_CALL             = 5'h04,
    ZERO_FILL            = 5'h05,
    ZERO_FILL_ACCUM      = 5'h06,
    WATCHDOG_RESTART     = 5'h07,
    BIT_INVERT           = 5'h08,
    SUBTRACT_COMPARE     = 5'h09,
    ZERO_COMPARE         = 5'h0A,
    BORROW_COMPARE       = 5'h0B,
    SKIP_ON_EQUAL        = 5'h0C,
    SKIP_ON_GREATER      = 5'h0D,
    SKIP_ON_LESS         = 5'h0E,
    SKIP_ON_UNEQUAL      = 5'h0F,
    BCD_FIXUP            = 5'h10,
    SUBTRACT_ONE         = 5'h11
  } op_e;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_HOLD = 1'b1
  } exec_state_e;
endpackage
`default_nettype wire

// ---- flag_subtractor.sv ----
// subtractor with carry, half carry, negative, signed wrap and zero flags
`include "bit_ops_defs.svh"
`default_nettype none
module flag_subtractor (
  input  wire logic [15:0] minuend,
  input  wire logic [15:0] subtrahend,
  input  wire logic        carry_in,
  output logic      [15:0] diff,
  output logic      [4:0]  flags
);
  logic [16:0] wide;
  logic [4:0]  low;

  // a - b - !carry_in as a + ~b + carry_in
  always_comb begin
    wide = {1'b0, minuend} + {1'b0, ~subtrahend} + {16'h0000, carry_in};
    low  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
    diff = wide[15:0];
    flags             = `FLAGS_RESET;
    flags[`FLAG_C]    = wide[16];
    flags[`FLAG_DC]   = low[4];
    flags[`FLAG_N]    = wide[15];
    flags[`FLAG_OV]   = (minuend[15] != subtrahend[15]) && (wide[15] != minuend[15]);
    flags[`FLAG_Z]    = (wide[15:0] == `ZERO_WORD);
  end
endmodule
`default_nettype wire

// ---- bit_ops_exec.sv ----
// execution slice: bit tests, skips, call, clears, complement, compares, adjust, decrement
//
// Function
// [RULE1] skip_if_bit_low skips on selected bit zero, no flags, 1 or 2/3 cycles
// [RULE2] skip_if_bit_high skips on selected bit one, no flags, same cycle cost
// [RULE3] bit_probe reports selected bit into zero or carry, literal or register index
// [RULE4] bit_probe_then_force reports the bit, then sets it, in one cycle
// [RULE5] call: literal form two words two cycles, register form one word two cycles
// [RULE6] zero_fill writes 0x0000 to destination in one cycle, no flags
// [RULE7] accumulator clear is one cycle and updates both wrap and clamp flags
// [RULE8] watchdog_restart restarts watchdog, clears timeout and sleep flags; the slice only pulses WATCHDOG_RESTART_PULSE
// [RULE9] complement inverts source, writes destination, updates negative and zero only
// [RULE10] subtract_compare computes a minus b, no store, updates five arithmetic flags
// [RULE11] zero_compare subtracts 0x0000, no store, five arithmetic flags, one cycle
// [RULE12] borrow_compare computes a minus b minus not-carry, five arithmetic flags
// [RULE13] compare-and-skip on equal/greater/less/unequal, no flags, 1 or 2/3 cycles
// [RULE14] bcd_fixup corrects a binary sum to packed decimal, alters carry only
// [RULE15] subtract_one writes source minus one, updates five arithmetic flags
// [RULE16] zero variant sets zero when bit is 0; carry variant copies bit
`include "bit_ops_defs.svh"
`default_nettype none
module bit_ops_exec
  import bit_ops_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic        OP_VALID,
  output logic             OP_READY,
  input  wire op_e         OP_CODE,
  input  wire logic        CARRY_VARIANT,
  input  wire logic        BIT_FROM_REG,
  input  wire logic        CALL_FROM_REG,
  input  wire logic        NEXT_TWO_WORD,
  input  wire logic        ACC_SEL,
  input  wire logic [3:0]  BIT_SEL,
  input  wire logic [15:0] OPERAND_A,
  input  wire logic [15:0] OPERAND_B,
  input  wire logic [22:0] CALL_LITERAL,
  input  wire logic [4:0]  FLAGS_IN,
  input  wire logic [3:0]  ACC_FLAGS_IN,
  output logic             DONE,
  output logic [15:0]      RESULT,
  output logic             RESULT_WRITE,
  output logic [4:0]       FLAGS,
  output logic [4:0]       FLAGS_WRITE,
  output logic [3:0]       ACC_FLAGS,
  output logic             ACC_FLAGS_WRITE,
  output logic             SKIP,
  output logic [1:0]       CYCLES,
  output logic             CALL_TAKEN,
  output logic [22:0]      CALL_TARGET,
  output logic [1:0]       CALL_WORDS,
  output logic             WATCHDOG_RESTART_PULSE
);

  localparam logic [4:0] ARITH_MASK = 5'h1F;
  localparam logic [4:0] NZ_MASK    = 5'h14;

  exec_state_e state;
  exec_state_e next_state;
  logic [1:0]  remain;
  logic [1:0]  next_remain;
  logic        next_done;
  logic [15:0] next_result;
  logic        next_result_write;
  logic [4:0]  next_flags;
  logic [4:0]  next_flags_write;
  logic [3:0]  next_acc_flags;
  logic        next_acc_flags_write;
  logic        next_skip;
  logic [1:0]  next_cycles;
  logic        next_call_taken;
  logic [22:0] next_call_target;
  logic [1:0]  next_call_words;
  logic        next_wdt;

  logic        accept;
  logic [3:0]  bit_index;
  logic [15:0] bit_mask;
  logic        probe_bit;
  logic [15:0] sub_b;
  logic        sub_cin;
  logic [15:0] sub_diff;
  logic [4:0]  sub_flags;
  logic [8:0]  bcd_first;
  logic [8:0]  bcd_second;
  logic        bcd_hi;
  logic        cmp_hit;
  logic [1:0]  skip_cycles;

  ////////////////////////////////////////////////////////////////////////////
  // operand steering

  assign OP_READY  = (state == ST_IDLE);
  assign accept    = OP_VALID && OP_READY;
  assign bit_index = BIT_FROM_REG ? OPERAND_B[3:0] : BIT_SEL; // see [RULE3]
  assign bit_mask  = `ONE_WORD << bit_index;
  assign probe_bit = OPERAND_A[bit_index];

  always_comb begin
    sub_b   = OPERAND_B;
    sub_cin = 1'b1;
    unique case (OP_CODE)
      BORROW_COMPARE: sub_cin = FLAGS_IN[`FLAG_C]; // see [RULE12]
      ZERO_COMPARE:   sub_b   = `ZERO_WORD;        // see [RULE11]
      SUBTRACT_ONE:   sub_b   = `ONE_WORD;         // see [RULE15]
      default:        sub_b   = OPERAND_B;         // see [RULE10]
    endcase
  end

  flag_subtractor flag_subtractor_i (
    .minuend    (OPERAND_A),
    .subtrahend (sub_b),
    .carry_in   (sub_cin),
    .diff       (sub_diff),
    .flags      (sub_flags)
  );

  // decimal adjust of the low byte
  always_comb begin
    bcd_first  = {1'b0, OPERAND_A[7:0]};
    if ((OPERAND_A[3:0] > `BCD_NIBBLE_MAX) || FLAGS_IN[`FLAG_DC]) begin
      bcd_first = {1'b0, OPERAND_A[7:0]} + `BCD_ADJ_LO;
    end
    bcd_hi     = (bcd_first[7:4] > `BCD_NIBBLE_MAX) || FLAGS_IN[`FLAG_C] || bcd_first[8];
    bcd_second = bcd_hi ? ({1'b0, bcd_first[7:0]} + `BCD_ADJ_HI) : {1'b0, bcd_first[7:0]};
  end

  // compare-and-skip conditions, signed
  always_comb begin
    unique case (OP_CODE)
      SKIP_ON_EQUAL:   cmp_hit = (OPERAND_A == OPERAND_B);
      SKIP_ON_GREATER: cmp_hit = ($signed(OPERAND_A) > $signed(OPERAND_B));
      SKIP_ON_LESS:    cmp_hit = ($signed(OPERAND_A) < $signed(OPERAND_B));
      SKIP_ON_UNEQUAL: cmp_hit = (OPERAND_A != OPERAND_B);
      default:         cmp_hit = 1'b0;
    endcase
  end

  assign skip_cycles = NEXT_TWO_WORD ? `CYC_THREE : `CYC_TWO;

  ////////////////////////////////////////////////////////////////////////////
  // next values

  always_comb begin
    next_state           = state;
    next_remain          = remain;
    next_done            = 1'b0;
    next_result          = RESULT;
    next_result_write    = 1'b0;
    next_flags           = FLAGS;
    next_flags_write     = `FLAGS_RESET;
    next_acc_flags       = ACC_FLAGS;
    next_acc_flags_write = 1'b0;
    next_skip            = 1'b0;
    next_cycles          = CYCLES;
    next_call_taken      = 1'b0;
    next_call_target     = CALL_TARGET;
    next_call_words      = CALL_WORDS;
    next_wdt             = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (accept) begin
          next_done   = 1'b1;
          next_cycles = `CYC_ONE;
          next_flags  = FLAGS_IN;
          unique case (OP_CODE)
            BIT_PROBE, BIT_PROBE_THEN_FORCE: begin
              if (CARRY_VARIANT) begin
                next_flags[`FLAG_C]       = probe_bit;  // see [RULE16]
                next_flags_write[`FLAG_C] = 1'b1;       // see [RULE3]
              end else begin
                next_flags[`FLAG_Z]       = !probe_bit; // see [RULE16]
                next_flags_write[`FLAG_Z] = 1'b1;       // see [RULE3]
              end
              if (OP_CODE == BIT_PROBE_THEN_FORCE) begin
                next_result       = OPERAND_A | bit_mask; // see [RULE4]
                next_result_write = 1'b1;
              end
            end
            SKIP_IF_BIT_LOW: begin
              next_skip   = !probe_bit;                          // see [RULE1]
              next_cycles = !probe_bit ? skip_cycles : `CYC_ONE; // see [RULE1]
            end
            SKIP_IF_BIT_HIGH: begin
              next_skip   = probe_bit;                          // see [RULE2]
              next_cycles = probe_bit ? skip_cycles : `CYC_ONE; // see [RULE2]
            end
            SKIP_ON_EQUAL, SKIP_ON_GREATER, SKIP_ON_LESS, SKIP_ON_UNEQUAL: begin
              next_skip   = cmp_hit;                          // see [RULE13]
              next_cycles = cmp_hit ? skip_cycles : `CYC_ONE; // see [RULE13]
            end
            SUB_CALL: begin
              next_call_taken  = 1'b1;
              next_cycles      = `CYC_TWO; // see [RULE5]
              next_call_target = CALL_FROM_REG ? {7'h00, OPERAND_A} : CALL_LITERAL;
              next_call_words  = CALL_FROM_REG ? `WORDS_ONE : `WORDS_TWO; // see [RULE5]
            end
            ZERO_FILL: begin
              next_result       = `ZERO_WORD; // see [RULE6]
              next_result_write = 1'b1;
            end
            ZERO_FILL_ACCUM: begin
              next_acc_flags = ACC_FLAGS_IN;
              if (ACC_SEL) begin
                next_acc_flags[`ACC_OB] = 1'b0; // see [RULE7]
                next_acc_flags[`ACC_SB] = 1'b0;
              end else begin
                next_acc_flags[`ACC_OA] = 1'b0; // see [RULE7]
                next_acc_flags[`ACC_SA] = 1'b0;
              end
              next_acc_flags_write = 1'b1;
            end
            WATCHDOG_RESTART: next_wdt = 1'b1; // see [RULE8]
            BIT_INVERT: begin
              next_result          = ~OPERAND_A;                // see [RULE9]
              next_result_write    = 1'b1;
              next_flags[`FLAG_N]  = !OPERAND_A[15];
              next_flags[`FLAG_Z]  = (OPERAND_A == 16'hFFFF);
              next_flags_write     = NZ_MASK;                   // see [RULE9]
            end
            SUBTRACT_COMPARE, ZERO_COMPARE, BORROW_COMPARE: begin
              next_flags       = sub_flags;  // see [RULE10] [RULE11] [RULE12]
              next_flags_write = ARITH_MASK;
            end
            SUBTRACT_ONE: begin
              next_result       = sub_diff; // see [RULE15]
              next_result_write = 1'b1;
              next_flags        = sub_flags;
              next_flags_write  = ARITH_MASK;
            end
            BCD_FIXUP: begin
              next_result               = {OPERAND_A[15:8], bcd_second[7:0]}; // see [RULE14]
              next_result_write         = 1'b1;
              next_flags[`FLAG_C]       = bcd_second[8] || bcd_first[8];
              next_flags_write[`FLAG_C] = 1'b1; // see [RULE14]
            end
            default: next_done = 1'b1;
          endcase
          next_remain = next_cycles - `CYC_ONE;
          if (next_remain != 2'h0) begin
            next_state = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        next_remain = remain - 2'h1;
        if (remain == 2'h1) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      state                  <= ST_IDLE;
      remain                 <= 2'h0;
      DONE                   <= 1'b0;
      RESULT                 <= `ZERO_WORD;
      RESULT_WRITE           <= 1'b0;
      FLAGS                  <= `FLAGS_RESET;
      FLAGS_WRITE            <= `FLAGS_RESET;
      ACC_FLAGS              <= `ACC_RESET;
      ACC_FLAGS_WRITE        <= 1'b0;
      SKIP                   <= 1'b0;
      CYCLES                 <= `CYC_ONE;
      CALL_TAKEN             <= 1'b0;
      CALL_TARGET            <= `CALL_RESET;
      CALL_WORDS             <= `WORDS_ONE;
      WATCHDOG_RESTART_PULSE <= 1'b0;
    end else begin
      state                  <= next_state;
      remain                 <= next_remain;
      DONE                   <= next_done;
      RESULT                 <= next_result;
      RESULT_WRITE           <= next_result_write;
      FLAGS                  <= next_flags;
      FLAGS_WRITE            <= next_flags_write;
      ACC_FLAGS              <= next_acc_flags;
      ACC_FLAGS_WRITE        <= next_acc_flags_write;
      SKIP                   <= next_skip;
      CYCLES                 <= next_cycles;
      CALL_TAKEN             <= next_call_taken;
      CALL_TARGET            <= next_call_target;
      CALL_WORDS             <= next_call_words;
      WATCHDOG_RESTART_PULSE <= next_wdt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_SKIP_LOW: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // see [RULE1]
    accept && OP_CODE == SKIP_IF_BIT_LOW |=> SKIP == !$past(probe_bit) && FLAGS_WRITE == 5'h00)
    else $error("skip on low bit wrong");
  AST_SKIP_HIGH: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // see [RULE2]
    accept && OP_CODE == SKIP_IF_BIT_HIGH && NEXT_TWO_WORD && probe_bit
    |=> SKIP && !OP_READY ##1 !OP_READY ##1 OP_READY)
    else $error("skip on high bit timing wrong");
  AST_PROBE_ZERO: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // see [RULE16]
    accept && OP_CODE == BIT_PROBE && !CARRY_VARIANT
    |=> FLAGS[4] == !$past(probe_bit) && FLAGS_WRITE == 5'h10 && !RESULT_WRITE)
    else $error("zero flag probe wrong");
  AST_PROBE_FORCE: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // see [RULE4]
    accept && OP_CODE == BIT_PROBE_THEN_FORCE && CARRY_VARIANT
    |=> RESULT == ($past(OPERAND_A) | $past(bit_mask)) && FLAGS[0] == $past(probe_bit))
    else $error("probe then force wrong");
  AST_CALL_TWO: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // see [RULE5]
    accept && OP_CODE == SUB_CALL |=> CALL_TAKEN && !OP_READY ##1 OP_READY && !CALL_TAKEN)
    else $error("call not two cycles");
  AST_ZERO_FILL: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // see [RULE6]
    accept && OP_CODE == ZERO_FILL |=> RESULT == 16'h0000 && RESULT_WRITE && FLAGS_WRITE == 5'h00)
    else $error("zero fill wrong");
  AST_INVERT: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // see [RULE9]
    accept && OP_CODE == BIT_INVERT |=> RESULT == ~$past(OPERAND_A) && FLAGS_WRITE == 5'h14)
    else $error("complement wrong");
  AST_ZERO_CMP: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // see [RULE11]
    accept && OP_CODE == ZERO_COMPARE |=> FLAGS[0] && !RESULT_WRITE && FLAGS_WRITE == 5'h1F)
    else $error("zero compare wrong");
  AST_DEC: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // see [RULE15]
    accept && OP_CODE == SUBTRACT_ONE |=> RESULT == $past(OPERAND_A) - 16'h0001 && OP_READY)
    else $error("decrement wrong");
  AST_CMP_SKIP: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // see [RULE13]
    accept && OP_CODE == SKIP_ON_EQUAL && OPERAND_A != OPERAND_B
    |=> !SKIP && CYCLES == 2'h1 && OP_READY)
    else $error("compare skip wrong");

endmodule
`default_nettype wire

// ---- tb_bit_ops_exec.sv ----
// self-checking bench of the bit test, compare and decrement slice
`include "bit_ops_defs.svh"
`default_nettype none
module tb_bit_ops_exec
  import bit_ops_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, reset_n, op_valid, op_ready, carry_variant, bit_from_reg, call_from_reg;
  logic next_two_word, acc_sel, done, result_write, acc_flags_write, skip, call_taken, wd_pulse;
  op_e         op_code;
  logic [3:0]  bit_sel, acc_flags_in, acc_flags;
  logic [15:0] operand_a, operand_b, result;
  logic [22:0] call_literal, call_target;
  logic [4:0]  flags_in, flags, flags_write;
  logic [1:0]  cycles, call_words;
  int          error_cnt = 0;
  int          checks = 0;
  bit_ops_exec bit_ops_exec_i (.REF_CLK(ref_clk), .RESET_N(reset_n), .OP_VALID(op_valid),
    .OP_READY(op_ready), .OP_CODE(op_code), .CARRY_VARIANT(carry_variant),
    .BIT_FROM_REG(bit_from_reg), .CALL_FROM_REG(call_from_reg), .NEXT_TWO_WORD(next_two_word),
    .ACC_SEL(acc_sel), .BIT_SEL(bit_sel), .OPERAND_A(operand_a), .OPERAND_B(operand_b),
    .CALL_LITERAL(call_literal), .FLAGS_IN(flags_in), .ACC_FLAGS_IN(acc_flags_in), .DONE(done),
    .RESULT(result), .RESULT_WRITE(result_write), .FLAGS(flags), .FLAGS_WRITE(flags_write),
    .ACC_FLAGS(acc_flags), .ACC_FLAGS_WRITE(acc_flags_write), .SKIP(skip), .CYCLES(cycles),
    .CALL_TAKEN(call_taken), .CALL_TARGET(call_target), .CALL_WORDS(call_words),
    .WATCHDOG_RESTART_PULSE(wd_pulse));
  always #50 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic logic [20:0] ref_sub(input logic [15:0] a, input logic [15:0] b,
                                          input logic cin);
    logic [16:0] f;
    logic [4:0]  n;
    f = {1'b0, a} + {1'b0, ~b} + {16'h0000, cin};
    n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    ref_sub = {f[15:0] == 16'h0000, (a[15] != b[15]) && (f[15] != a[15]), f[15], n[4], f[16],
               f[15:0]};
  endfunction
  // mode: 0 carry variant, 1 index from reg, 2 call from reg, 3 next two word, 4 accum b
  task automatic issue(input op_e op, input logic [15:0] a, input logic [15:0] b,
                       input logic [4:0] fl, input logic [4:0] mode, input logic [3:0] bs);
    int n = 0;
    @(posedge ref_clk);
    op_valid      <= 1'b1;
    op_code       <= op;
    operand_a     <= a;
    operand_b     <= b;
    flags_in      <= fl;
    bit_sel       <= bs;
    carry_variant <= mode[0];
    bit_from_reg  <= mode[1];
    call_from_reg <= mode[2];
    next_two_word <= mode[3];
    acc_sel       <= mode[4];
    @(negedge ref_clk);
    while (op_ready !== 1'b1 && n < 8) begin
      n++;
      @(negedge ref_clk);
    end
    if (n == 8) begin
      error_cnt++;
      $display("[ERR] t=%0t request never taken", $time);
    end
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1;
  endtask
  task automatic wait_ready(input logic [1:0] cyc);
    for (int k = 1; k < cyc; k++) begin
      @(negedge ref_clk);
      check(op_ready, 1'b0);
    end
    @(negedge ref_clk);
    check(op_ready, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_probe();
    logic [4:0] e;
    logic       bv;
    for (int i = 0; i < 32; i++) begin
      bv = 16'hA5C3 >> i[3:0];
      issue(i[4] ? BIT_PROBE_THEN_FORCE : BIT_PROBE, 16'hA5C3,
            i[0] ? {12'h000, i[3:0]} : {12'hFFF, ~i[3:0]}, 5'h0A, {3'b000, i[0], i[1]},
            i[0] ? ~i[3:0] : i[3:0]);
      e = 5'h0A;
      if (i[1]) e[`FLAG_C] = bv;
      else e[`FLAG_Z] = !bv;
      check(flags, e);
      check(flags_write, i[1] ? 5'h01 : 5'h10);
      check(result_write, i[4]);
      if (i[4]) check(result, 16'hA5C3 | (16'h0001 << i[3:0]));
    end
  endtask
  task automatic t_skip();
    logic       sk;
    logic [1:0] cyc;
    for (int i = 0; i < 8; i++) begin
      sk = i[0] ^ i[1];
      cyc = !sk ? 2'h1 : (i[2] ? 2'h3 : 2'h2);
      issue(i[0] ? SKIP_IF_BIT_HIGH : SKIP_IF_BIT_LOW, 16'h0001, 16'h0000, 5'h1F,
            {1'b0, i[2], 3'b000}, {3'b000, i[1]});
      check(skip, sk);
      check(cycles, cyc);
      check(flags_write, 5'h00);
      wait_ready(cyc);
    end
  endtask
  task automatic t_cskip();
    logic [15:0] pa [4];
    logic [15:0] pb [4];
    op_e         ops [4];
    logic        sk;
    logic [1:0]  cyc;
    pa = '{16'h0005, 16'h8000, 16'h0001, 16'h7FFF};
    pb = '{16'h0005, 16'h0001, 16'h8000, 16'hFFFF};
    ops = '{SKIP_ON_EQUAL, SKIP_ON_GREATER, SKIP_ON_LESS, SKIP_ON_UNEQUAL};
    for (int j = 0; j < 4; j++) begin
      for (int k = 0; k < 4; k++) begin
        case (k)
          0: sk = pa[j] == pb[j];
          1: sk = $signed(pa[j]) > $signed(pb[j]);
          2: sk = $signed(pa[j]) < $signed(pb[j]);
          default: sk = pa[j] != pb[j];
        endcase
        cyc = !sk ? 2'h1 : (j[0] ? 2'h3 : 2'h2);
        issue(ops[k], pa[j], pb[j], 5'h00, {1'b0, j[0], 3'b000}, 4'h0);
        check(skip, sk);
        check(cycles, cyc);
        check(flags_write, 5'h00);
        wait_ready(cyc);
      end
    end
  endtask
  task automatic t_call_clear();
    for (int i = 0; i < 2; i++) begin
      issue(SUB_CALL, 16'hBEEF, 16'h0000, 5'h00, {2'b00, i[0], 2'b00}, 4'h0);
      check(done, 1'b1);
      check(call_taken, 1'b1);
      check(call_target, i[0] ? 23'h00BEEF : 23'h5A5A5A);
      check(call_words, i[0] ? 2'h1 : 2'h2);
      check(cycles, 2'h2);
      check(flags_write, 5'h00);
      wait_ready(2'h2);
      issue(ZERO_FILL_ACCUM, 16'h1234, 16'h0000, 5'h00, {i[0], 4'h0}, 4'h0);
      check(acc_flags, i[0] ? 4'h5 : 4'hA);
      check(acc_flags_write, 1'b1);
    end
    issue(ZERO_FILL, 16'hFFFF, 16'hFFFF, 5'h1F, 5'h00, 4'h0);
    check(result, 16'h0000);
    check(result_write, 1'b1);
    check(flags_write, 5'h00);
    issue(WATCHDOG_RESTART, 16'h0000, 16'h0000, 5'h00, 5'h00, 4'h0);
    check(wd_pulse, 1'b1);
  endtask
  task automatic t_arith();
    logic [15:0] va [4];
    logic [20:0] r;
    logic [4:0]  e;
    va = '{16'h0000, 16'h8000, 16'h0001, 16'h7FF8};
    for (int i = 0; i < 4; i++) begin
      issue(SUBTRACT_COMPARE, va[i], va[3-i], 5'h00, 5'h00, 4'h0);
      r = ref_sub(va[i], va[3-i], 1'b1);
      check(flags, r[20:16]);
      check(flags_write, 5'h1F);
      check(result_write, 1'b0);
      issue(ZERO_COMPARE, va[i], 16'hFFFF, 5'h00, 5'h00, 4'h0);
      r = ref_sub(va[i], 16'h0000, 1'b1);
      check(flags, r[20:16]);
      check(result_write, 1'b0);
      issue(BORROW_COMPARE, va[i], va[3-i], {4'h0, i[0]}, 5'h00, 4'h0);
      r = ref_sub(va[i], va[3-i], i[0]);
      check(flags, r[20:16]);
      check(result_write, 1'b0);
      issue(SUBTRACT_ONE, va[i], 16'h0000, 5'h00, 5'h00, 4'h0);
      r = ref_sub(va[i], 16'h0001, 1'b1);
      check(result, r[15:0]);
      check(flags, r[20:16]);
      check(result_write, 1'b1);
      issue(BIT_INVERT, ~va[i], 16'h0000, 5'h0B, 5'h00, 4'h0);
      e = 5'h0B;
      e[`FLAG_N] = va[i][15];
      e[`FLAG_Z] = va[i] == 16'h0000;
      check(result, va[i]);
      check(flags, e);
      check(flags_write, 5'h14);
    end
  endtask
  task automatic t_bcd();
    logic [15:0] ta [3];
    logic [15:0] tr [3];
    logic [4:0]  tf [3];
    logic        tc [3];
    ta = '{16'h3415, 16'h559A, 16'h0012};
    tr = '{16'h3415, 16'h5500, 16'h0018};
    tf = '{5'h00, 5'h00, 5'h02};
    tc = '{1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      issue(BCD_FIXUP, ta[i], 16'h0000, tf[i], 5'h00, 4'h0);
      check(result, tr[i]);
      check(flags, {tf[i][4:1], tc[i]});
      check(flags_write, 5'h01);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    op_valid = 1'b0;
    op_code = BIT_PROBE;
    {carry_variant, bit_from_reg, call_from_reg, next_two_word, acc_sel} = 5'h00;
    bit_sel = 4'h0;
    operand_a = 16'h0000;
    operand_b = 16'h0000;
    flags_in = 5'h00;
    acc_flags_in = 4'hF;
    call_literal = 23'h5A5A5A;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_probe();
    t_skip();
    t_cskip();
    t_call_clear();
    t_arith();
    t_bcd();
    stop_test();
  end
  initial begin
    #200000;
    error_cnt++;
    $display("[ERR] t=%0t run did not finish", $time);
    stop_test();
  end
endmodule
`default_nettype wire
